//--- hdl/irq_flag_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module irq_flag_ctrl (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic [15:0] src_req_zero, // request pulses, flags zero
    input wire logic [15:0] src_req_one, // request pulses, flags one
    input wire logic [15:0] src_req_two, // request pulses, flags two
    input wire logic [4:0] ext_irq_pin, // external interrupt levels
    input wire logic irq_disable_instr_active, // disable instruction running
    output logic alt_vector_table_select, // alternate table in use
    output logic [4:0] ext_irq_edge, // qualified edge pulses
    output logic [15:0] fwd_req_zero, // enabled flags zero
    output logic [15:0] fwd_req_one, // enabled flags one
    output logic [15:0] fwd_req_two, // enabled flags two
    output logic irq // summary interrupt
);
    // ****************************************
    // bus slave
    // ****************************************
    logic [7:0] dp_addr;
    logic dp_write;
    logic dp_valid;
    logic [15:0] ctrl_two;
    logic [15:0] flags_zero;
    logic [15:0] flags_one;
    logic [15:0] flags_two;
    logic [15:0] enable_zero;
    logic [15:0] enable_one;
    logic [15:0] enable_two;
    logic [2:0] irq_status;
    logic [2:0] irq_enable;
    logic [4:0] pin_prev;

    wire addr_take = hsel && hready && (htrans == irq_flag_pkg::HTRANS_NONSEQ);
    wire wr_phase = dp_valid && dp_write;
    wire rd_phase = dp_valid && !dp_write;
    wire wr_ctrl = wr_phase && (dp_addr == irq_flag_pkg::OFF_CTRL_TWO);
    wire wr_f0 = wr_phase && (dp_addr == irq_flag_pkg::OFF_FLAGS_ZERO);
    wire wr_f1 = wr_phase && (dp_addr == irq_flag_pkg::OFF_FLAGS_ONE);
    wire wr_f2 = wr_phase && (dp_addr == irq_flag_pkg::OFF_FLAGS_TWO);
    wire wr_e0 = wr_phase && (dp_addr == irq_flag_pkg::OFF_ENABLE_ZERO);
    wire wr_e1 = wr_phase && (dp_addr == irq_flag_pkg::OFF_ENABLE_ONE);
    wire wr_e2 = wr_phase && (dp_addr == irq_flag_pkg::OFF_ENABLE_TWO);
    wire wr_clr = wr_phase && (dp_addr == irq_flag_pkg::OFF_IRQ_CLEAR);
    wire wr_ien = wr_phase && (dp_addr == irq_flag_pkg::OFF_IRQ_ENABLE);
    wire [15:0] wd = hwdata[15:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_valid <= addr_take;
            if (addr_take) begin
                dp_write <= hwrite;
                dp_addr <= {haddr[7:2], 2'h0};
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ****************************************
    // control register two
    // ****************************************
    wire [15:0] ctrl_two_view = (ctrl_two & irq_flag_pkg::CTRL_TWO_MASK)
        | ({15'h0000, irq_disable_instr_active} << irq_flag_pkg::DIS_INSTR_BIT);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_two <= irq_flag_pkg::REG_RESET;
        end else if (wr_ctrl) begin
            ctrl_two <= wd & irq_flag_pkg::CTRL_TWO_MASK;
        end
    end

    assign alt_vector_table_select = ctrl_two[irq_flag_pkg::ALT_VT_BIT];

    AST_CTRL_POL_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> (ctrl_two[4:0] == $past(hwdata[4:0])))
        else $error("edge polarity bits did not follow write");

    AST_CTRL_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        !wr_ctrl |=> $stable(ctrl_two))
        else $error("control register changed without a write");

    // ****************************************
    // external edge detection
    // ****************************************
    wire [4:0] rise = ext_irq_pin & ~pin_prev;
    wire [4:0] fall = ~ext_irq_pin & pin_prev;
    wire [4:0] pol = ctrl_two[4:0];
    assign ext_irq_edge = (pol & fall) | (~pol & rise);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_prev <= 5'h00;
        end else begin
            pin_prev <= ext_irq_pin;
        end
    end

    AST_EXT0_FALL: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_two[0] && pin_prev[0] && !ext_irq_pin[0]) |=> flags_zero[0])
        else $error("falling edge did not set external flag zero");

    AST_EXT2_RISE: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ctrl_two[2] && !pin_prev[2] && ext_irq_pin[2]) |=> flags_one[13])
        else $error("rising edge did not set external flag two");

    AST_EXT3_NO_RISE: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_two[3] && !pin_prev[3] && ext_irq_pin[3]) |-> !ext_irq_edge[3])
        else $error("rising edge taken while falling edge selected");

    AST_EDGE_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
        (ext_irq_pin == pin_prev) |-> (ext_irq_edge == 5'h00))
        else $error("edge pulse without a pin change");

    // ****************************************
    // request flags
    // ****************************************
    wire [15:0] hw_set_zero = (src_req_zero
        | (16'h0001 << irq_flag_pkg::EXT0_POS) & {15'h0000, ext_irq_edge[0]})
        & irq_flag_pkg::IMPL_ZERO;
    wire [15:0] ext_one = ({15'h0000, ext_irq_edge[1]} << irq_flag_pkg::EXT1_POS)
        | ({15'h0000, ext_irq_edge[2]} << irq_flag_pkg::EXT2_POS);
    wire [15:0] hw_set_one = (src_req_one | ext_one) & irq_flag_pkg::IMPL_ONE;
    wire [15:0] hw_set_two = src_req_two & irq_flag_pkg::IMPL_TWO;

    // hardware set wins over a write of zero in the same cycle
    wire [15:0] next_flags_zero = (wr_f0 ? wd & irq_flag_pkg::IMPL_ZERO : flags_zero)
        | hw_set_zero;
    wire [15:0] next_flags_one = (wr_f1 ? wd & irq_flag_pkg::IMPL_ONE : flags_one)
        | hw_set_one;
    wire [15:0] next_flags_two = (wr_f2 ? wd & irq_flag_pkg::IMPL_TWO : flags_two)
        | hw_set_two;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_zero <= irq_flag_pkg::REG_RESET;
            flags_one <= irq_flag_pkg::REG_RESET;
            flags_two <= irq_flag_pkg::REG_RESET;
        end else begin
            flags_zero <= next_flags_zero;
            flags_one <= next_flags_one;
            flags_two <= next_flags_two;
        end
    end

    AST_F0_HIGH_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        src_req_zero[14] |=> flags_zero[14])
        else $error("source request did not set flags zero bit 14");

    AST_F0_LOW_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        src_req_zero[4] |=> flags_zero[4])
        else $error("source request did not set flags zero bit 4");

    AST_F1_HIGH_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        src_req_one[8] |=> flags_one[8])
        else $error("source request did not set flags one bit 8");

    AST_F1_LOW_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        src_req_one[0] |=> flags_one[0])
        else $error("source request did not set flags one bit 0");

    AST_F2_HIGH_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        src_req_two[14] |=> flags_two[14])
        else $error("source request did not set flags two bit 14");

    AST_F2_LOW_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        src_req_two[3] |=> flags_two[3])
        else $error("source request did not set flags two bit 3");

    AST_FLAGS_ONE_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        (!wr_f1 && hw_set_one == 16'h0000) |=> $stable(flags_one))
        else $error("flags one changed without request or write");

    AST_SW_WRITE_ONE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_f1 && hw_set_one == 16'h0000) |=> (flags_one == ($past(hwdata[15:0]) & irq_flag_pkg::IMPL_ONE)))
        else $error("software write to flags one not stored");

    AST_SW_WRITE_TWO: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_f2 && hw_set_two == 16'h0000) |=> (flags_two == ($past(hwdata[15:0]) & irq_flag_pkg::IMPL_TWO)))
        else $error("software write to flags two not stored");

    // ****************************************
    // per-source enables and forwarding
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_zero <= irq_flag_pkg::REG_RESET;
            enable_one <= irq_flag_pkg::REG_RESET;
            enable_two <= irq_flag_pkg::REG_RESET;
        end else begin
            if (wr_e0) begin
                enable_zero <= wd & irq_flag_pkg::IMPL_ZERO;
            end
            if (wr_e1) begin
                enable_one <= wd & irq_flag_pkg::IMPL_ONE;
            end
            if (wr_e2) begin
                enable_two <= wd & irq_flag_pkg::IMPL_TWO;
            end
        end
    end

    assign fwd_req_zero = flags_zero & enable_zero;
    assign fwd_req_one = flags_one & enable_one;
    assign fwd_req_two = flags_two & enable_two;

    AST_FWD_ENABLED: assert property (@(posedge hclk) disable iff (!hresetn)
        (flags_one[0] && enable_one[0]) |-> fwd_req_one[0])
        else $error("enabled flag was not forwarded");

    AST_EN_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_e0 |=> (enable_zero == ($past(hwdata[15:0]) & irq_flag_pkg::IMPL_ZERO)))
        else $error("enable write to register zero not stored");

    // ****************************************
    // summary interrupt
    // ****************************************
    // one event bit per flag register: an enabled source raised a request
    wire [2:0] ev = {|(hw_set_two & enable_two), |(hw_set_one & enable_one),
        |(hw_set_zero & enable_zero)};
    wire [2:0] clr = wr_clr ? wd[2:0] : 3'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= irq_flag_pkg::STAT_RESET;
            irq_enable <= irq_flag_pkg::STAT_RESET;
        end else begin
            irq_status <= (irq_status & ~clr) | ev;
            if (wr_ien) begin
                irq_enable <= wd[2:0];
            end
        end
    end

    assign irq = |(irq_status & irq_enable);

    AST_STATUS_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        ev[2] |=> irq_status[2])
        else $error("enabled event did not set status bit 2");

    AST_STATUS_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_clr && hwdata[0] && !ev[0]) |=> !irq_status[0])
        else $error("status bit 0 not cleared by write");

    AST_IRQ_MASKED: assert property (@(posedge hclk) disable iff (!hresetn)
        ((irq_status & irq_enable) == 3'h0) |-> !irq)
        else $error("interrupt raised with no enabled status");

    // ****************************************
    // read mux
    // ****************************************
    logic [15:0] rd_val;
    always_comb begin
        case (dp_addr)
            irq_flag_pkg::OFF_CTRL_TWO: rd_val = ctrl_two_view;
            irq_flag_pkg::OFF_FLAGS_ZERO: rd_val = flags_zero;
            irq_flag_pkg::OFF_FLAGS_ONE: rd_val = flags_one;
            irq_flag_pkg::OFF_FLAGS_TWO: rd_val = flags_two;
            irq_flag_pkg::OFF_ENABLE_ZERO: rd_val = enable_zero;
            irq_flag_pkg::OFF_ENABLE_ONE: rd_val = enable_one;
            irq_flag_pkg::OFF_ENABLE_TWO: rd_val = enable_two;
            irq_flag_pkg::OFF_IRQ_STATUS: rd_val = {13'h0000, irq_status};
            irq_flag_pkg::OFF_IRQ_ENABLE: rd_val = {13'h0000, irq_enable};
            default: rd_val = 16'h0000;
        endcase
    end

    assign hrdata = rd_phase ? {16'h0000, rd_val} : 32'h00000000;

    AST_HRDATA_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
        !rd_phase |-> (hrdata == 32'h00000000))
        else $error("read data driven outside a read data phase");

    AST_HRDATA_UPPER: assert property (@(posedge hclk) disable iff (!hresetn)
        hrdata[31:16] == 16'h0000)
        else $error("upper read data bits not zero");

    AST_READY_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("slave inserted a wait state or an error response");

    AST_FLAGS_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_phase && dp_addr == irq_flag_pkg::OFF_FLAGS_ZERO) |-> (hrdata == {16'h0000, flags_zero}))
        else $error("flags zero read back wrong");

    // ****************************************
    // checks
    // ****************************************
    AST_ALT_VT_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> (alt_vector_table_select == $past(hwdata[15])))
        else $error("alternate table select did not follow write");

    AST_DIS_INSTR_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_phase && dp_addr == 8'h00) |-> (hrdata[14] == irq_disable_instr_active))
        else $error("disable status bit wrong on read");

    AST_CTRL_GAP_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_phase && dp_addr == 8'h00) |-> (hrdata[13:5] == 9'h000))
        else $error("unimplemented control bits not zero");

    AST_EXT0_RISE: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ctrl_two[0] && !pin_prev[0] && ext_irq_pin[0]) |=> flags_zero[0])
        else $error("rising edge did not set external flag zero");

    AST_EXT1_FALL: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_two[1] && !ext_irq_pin[1] && $past(ext_irq_pin[1]) && $past(hresetn))
        |-> ext_irq_edge[1] ##1 flags_one[4])
        else $error("falling edge missed on external one");

    AST_HOLES_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        !flags_one[2] && !flags_two[13] && !flags_zero[15])
        else $error("unimplemented flag position set");

    AST_SET_BEATS_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_f0 && hw_set_zero != 16'h0000)
        |=> ((flags_zero & $past(hw_set_zero)) == $past(hw_set_zero)))
        else $error("request lost against clearing write");

    AST_FWD_GATED: assert property (@(posedge hclk) disable iff (!hresetn)
        (!enable_two[15] && !wr_e2 && src_req_two[15]) |=> (flags_two[15] && !fwd_req_two[15]))
        else $error("disabled source was forwarded");

    AST_IRQ_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
        (irq_enable[0] && !wr_ien && (hw_set_zero & enable_zero) != 16'h0000) |=> irq)
        else $error("enabled event did not raise interrupt");

    AST_SW_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_f0 && src_req_zero == 16'h0000 && !ext_irq_edge[0])
        |=> (flags_zero == ($past(hwdata[15:0]) & irq_flag_pkg::IMPL_ZERO)))
        else $error("software write to flags zero not stored");
endmodule
`default_nettype wire

//--- hdl/irq_flag_pkg.sv
// Operation
// - alt_vector_table_select at bit 15 of interrupt_control_two picks the alternate vector table when 1.
// - bit 14 of interrupt_control_two is read-only and reads 1 while a disable-interrupts instruction runs.
// - bits 13 to 5 of interrupt_control_two always read zero.
// - polarity bits 4 to 0 pick falling edge when 1, rising edge when 0, for external inputs 4 to 0.
// - each implemented flag reads 1 once its source requested and software may read and write it.
// - after reset every implemented control bit and flag is zero.
// - request_flags_zero bit 15 is absent and bits 14 to 8 hold dma1, adc1, uart1 tx/rx, spi1 event/fault, timer 3.
// - request_flags_zero bits 7 to 0 hold timer 2, oc2, ic2, dma0, timer 1, oc1, ic1 and external 0.
// - request_flags_one bits 15 to 8 hold uart2 tx/rx, external 2, timer 5, timer 4, oc4, oc3 and dma2.
// - request_flags_one bits 7 to 3 hold ic8, ic7, adc2, external 1, pin change, bit 2 is zero, bits 1 and 0 i2c1.
// - request_flags_two bits 15,14 hold timer 6 and dma4, bit 13 is zero, bits 12 to 9 oc8..oc5, bit 8 ic6.
// - request_flags_two bits 7 to 5 hold ic5..ic3, bit 4 dma3, bits 3 to 0 can1 event/rx, spi2 event/error.
// - absent flag positions of flag registers one and two always read zero.
// - a latched flag is forwarded only while its per-source enable bit is 1.
package irq_flag_pkg;
    localparam logic [7:0] OFF_CTRL_TWO = 8'h00;
    localparam logic [7:0] OFF_FLAGS_ZERO = 8'h04;
    localparam logic [7:0] OFF_FLAGS_ONE = 8'h08;
    localparam logic [7:0] OFF_FLAGS_TWO = 8'h0C;
    localparam logic [7:0] OFF_ENABLE_ZERO = 8'h10;
    localparam logic [7:0] OFF_ENABLE_ONE = 8'h14;
    localparam logic [7:0] OFF_ENABLE_TWO = 8'h18;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h20;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h24;
    localparam int ALT_VT_BIT = 15;
    localparam int DIS_INSTR_BIT = 14;
    localparam logic [15:0] CTRL_TWO_MASK = 16'h801F;
    localparam logic [15:0] IMPL_ZERO = 16'h7FFF;
    localparam logic [15:0] IMPL_ONE = 16'hFFFB;
    localparam logic [15:0] IMPL_TWO = 16'hDFFF;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [2:0] STAT_RESET = 3'h0;
    localparam int EXT0_POS = 0;
    localparam int EXT1_POS = 4;
    localparam int EXT2_POS = 13;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- testbench/req_source_model.sv
`timescale 1ns/100ps
`default_nettype none
module req_source_model (
    input wire logic hclk, // system clock
    output logic [15:0] src_req_zero, // request pulses, flags zero
    output logic [15:0] src_req_one, // request pulses, flags one
    output logic [15:0] src_req_two, // request pulses, flags two
    output logic [4:0] ext_irq_pin, // external levels
    output logic irq_disable_instr_active // cpu holds interrupts off
);
    // ***************************************
    // peripheral sources and cpu core
    // ***************************************
    initial begin
        src_req_zero = 16'h0000;
        src_req_one = 16'h0000;
        src_req_two = 16'h0000;
        ext_irq_pin = 5'h00;
        irq_disable_instr_active = 1'b0;
    end
    // each set bit is one request, high for exactly one cycle
    task automatic pulse(input logic [15:0] z, input logic [15:0] o, input logic [15:0] t);
        @(posedge hclk);
        src_req_zero <= z;
        src_req_one <= o;
        src_req_two <= t;
        @(posedge hclk);
        src_req_zero <= 16'h0000;
        src_req_one <= 16'h0000;
        src_req_two <= 16'h0000;
    endtask
    task automatic drive(input logic [4:0] pins, input logic dis);
        @(posedge hclk);
        ext_irq_pin <= pins;
        irq_disable_instr_active <= dis;
    endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hreadyout, hresp, alt_vector_table_select, irq, irq_disable_instr_active;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [15:0] src_req_zero, src_req_one, src_req_two, fwd_req_zero, fwd_req_one, fwd_req_two;
    logic [4:0] ext_irq_pin, ext_irq_edge;
    int error_cnt = 0;
    int cmp_count = 0;
    typedef struct packed {logic [7:0] a; logic [15:0] w; logic [31:0] e;} row_t;
    row_t rows [10] = '{'{8'h00, 16'hFFFF, 32'h801F}, '{8'h04, 16'hFFFF, 32'h7FFF}, '{8'h08, 16'hFFFF, 32'hFFFB},
        '{8'h0C, 16'hFFFF, 32'hDFFF}, '{8'h10, 16'hFFFF, 32'h7FFF}, '{8'h14, 16'hFFFF, 32'hFFFB},
        '{8'h18, 16'hFFFF, 32'hDFFF}, '{8'h1C, 16'hFFFF, 32'h0000}, '{8'h24, 16'hFFFF, 32'h0007},
        '{8'h30, 16'hFFFF, 32'h0000}};
    always #10 hclk = ~hclk;
    irq_flag_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .src_req_zero(src_req_zero), .src_req_one(src_req_one),
        .src_req_two(src_req_two), .ext_irq_pin(ext_irq_pin), .irq_disable_instr_active(irq_disable_instr_active),
        .alt_vector_table_select(alt_vector_table_select), .ext_irq_edge(ext_irq_edge),
        .fwd_req_zero(fwd_req_zero), .fwd_req_one(fwd_req_one), .fwd_req_two(fwd_req_two), .irq(irq));
    req_source_model u_src (.hclk(hclk), .src_req_zero(src_req_zero), .src_req_one(src_req_one),
        .src_req_two(src_req_two), .ext_irq_pin(ext_irq_pin), .irq_disable_instr_active(irq_disable_instr_active));
    // ***************************************
    // bus master and comparison
    // ***************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1 && n++ < 100);
        htrans <= 2'h0;
        hwdata <= {16'h0000, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1 && n++ < 100);
        rdv = hrdata;
        if (n >= 100) error_cnt++;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 16'h0000);
        check(rdv, e);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #40000;
        error_cnt++;
        conclude;
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h00000000;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd_reg(rows[i].a, 32'h0000);
            wr_reg(rows[i].a, rows[i].w);
            rd_reg(rows[i].a, rows[i].e);
        end
        check({fwd_req_zero, fwd_req_two}, 32'h7FFFDFFF);
        check({fwd_req_one, 15'h0000, hresp}, 32'hFFFB0000);
        check({31'h0, irq}, 32'h0);
        for (int i = 1; i < 4; i++) wr_reg(8'(4 * i), 16'h0000);
        for (int p = 0; p < 2; p++) begin
            wr_reg(8'h00, p ? 16'h001F : 16'h0000);
            u_src.drive(5'h1F, 1'b0);
            @(posedge hclk);
            check({27'h0, ext_irq_edge}, p ? 32'h00 : 32'h1F);
            u_src.drive(5'h00, 1'b0);
            @(posedge hclk);
            check({27'h0, ext_irq_edge}, p ? 32'h1F : 32'h00);
        end
        rd_reg(8'h04, 32'h0001);
        rd_reg(8'h08, 32'h2010);
        rd_reg(8'h1C, 32'h0003);
        check({31'h0, irq}, 32'h1);
        wr_reg(8'h20, 16'h0003);
        @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        u_src.drive(5'h00, 1'b1);
        wr_reg(8'h00, 16'h8000);
        rd_reg(8'h00, 32'hC000);
        check({31'h0, alt_vector_table_select}, 32'h1);
        wr_reg(8'h18, 16'h0001);
        u_src.pulse(16'hFFFF, 16'hFFFF, 16'hFFFF);
        rd_reg(8'h04, 32'h7FFF);
        rd_reg(8'h08, 32'hFFFB);
        rd_reg(8'h0C, 32'hDFFF);
        check({16'h0, fwd_req_two}, 32'h0001);
        rd_reg(8'h1C, 32'h0007);
        wr_reg(8'h24, 16'h0000);
        @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        fork
            wr_reg(8'h04, 16'h0000);
            u_src.pulse(16'h0008, 16'h0000, 16'h0000);
        join
        rd_reg(8'h04, 32'h0008);
        u_src.drive(5'h00, 1'b0);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd_reg(8'h00, 32'h0000);
        rd_reg(8'h04, 32'h0000);
        check({31'h0, alt_vector_table_select}, 32'h0);
        check({fwd_req_zero, fwd_req_one}, 32'h0);
        conclude;
    end
endmodule
`default_nettype wire
